// ==== verilog/ddeh_consts.vh ====
// Functional notes
// RULE_01: Delay timer works only while the channel delay field is non-zero.
// RULE_02: Descriptor with end-of-packet flag starts the delay timer counting up.
// RULE_03: Descriptor with start-of-packet flag clears the delay timer.
// RULE_04: Delay event zeroes the timer and holds it while the flag is set.
// RULE_05: Software clears the delay interrupt flag before counting resumes.
// RULE_06: Delay interrupt exists only in descriptor mode builds.
// RULE_07: Any error clears the channel run/stop bit and starts a halt.
// RULE_08: Halted sets only after all outstanding bus transfers complete.
// RULE_09: Descriptor mode logs failing descriptor address in current pointer.
// RULE_10: Simultaneous errors log exactly one descriptor pointer.
// RULE_11: After an error halt only a reset restarts the channel.
// RULE_12: Zero buffer length descriptor raises data mover internal error.
// RULE_13: Receive stream underflow against status length raises internal error.
// RULE_14: Without descriptor mode the internal error never reports.
// RULE_15: Payload slave error response raises data slave error.
// RULE_16: Payload decode error response raises data decode error.
// RULE_17: Fetched descriptor with completion bit set raises stale error.
// RULE_18: Descriptor path slave error response raises descriptor slave error.
// RULE_19: Descriptor path decode error response raises descriptor decode error.
// RULE_20: Descriptor errors stored only in channel status, never in memory.
// RULE_21: Priority: descriptor errors, then zero length, then other data errors.
// RULE_22: Slave and decode errors of one path never reported together.
// RULE_23: Enabled delay event reloads the coalescing threshold counter.
// RULE_24: Interrupt output rises on delay or error when enabled; the code drives it only in descriptor mode builds (SG_MODE non-zero).
// RULE_25: Delay event fires when count reaches the programmed non-zero delay.
`ifndef DDEH_CONSTS_VH
`define DDEH_CONSTS_VH
// Register offsets
`define DDEH_REG_CTRL 4'h0
`define DDEH_REG_STAT 4'h1
`define DDEH_REG_CDP 4'h2
`define DDEH_REG_THR 4'h3
// Control field positions
`define DDEH_CTRL_RS 0
`define DDEH_CTRL_DLY_IEN 13
`define DDEH_CTRL_ERR_IEN 14
`define DDEH_CTRL_DLY_LO 24
`define DDEH_CTRL_DLY_HI 31
// Status field positions
`define DDEH_ST_HALTED 0
`define DDEH_ST_DM_INT 4
`define DDEH_ST_DM_SLV 5
`define DDEH_ST_DM_DEC 6
`define DDEH_ST_SG_INT 8
`define DDEH_ST_SG_SLV 9
`define DDEH_ST_SG_DEC 10
`define DDEH_ST_DLY_IRQ 13
`define DDEH_ST_ERR_IRQ 14
`define DDEH_ST_DCNT_LO 24
`define DDEH_ST_DCNT_HI 31
// Reset values
`define DDEH_CTRL_RST 32'h00000000
`define DDEH_THR_RST 8'h01
`define DDEH_ZERO8 8'h00
`define DDEH_ZERO32 32'h00000000
`define DDEH_ONE8 8'h01
// Priority levels
`define DDEH_PRI_NONE 2'h0
`define DDEH_PRI_DESC 2'h1
`define DDEH_PRI_ZLEN 2'h2
`define DDEH_PRI_DATA 2'h3
`endif

// ==== verilog/ddeh_channel.v ====
`include "ddeh_consts.vh"

module ddeh_channel #(
    parameter SG_MODE = 1,
    parameter STS_LEN = 1,
    parameter PTR_W = 32
) (
    input wire core_clk,
    input wire srst,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_ff,
    input wire desc_valid,
    input wire desc_sof,
    input wire desc_eof,
    input wire desc_complete,
    input wire [22:0] desc_length,
    input wire [PTR_W-1:0] desc_addr,
    input wire [PTR_W-1:0] data_desc_addr,
    input wire rx_underflow,
    input wire data_resp_valid,
    input wire [1:0] data_resp,
    input wire sg_resp_valid,
    input wire [1:0] sg_resp,
    input wire [PTR_W-1:0] sg_resp_addr,
    input wire bus_outstanding,
    output reg run_ff,
    output reg halted_ff,
    output reg introut_ff,
    output reg thr_reload_ff
);

    localparam [1:0] RESP_SLV = 2'h2;
    localparam [1:0] RESP_DEC = 2'h3;
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN = 2'h1;
    localparam [1:0] ST_DRAIN = 2'h2;
    localparam [1:0] ST_HALT = 2'h3;

    // Priority level for a set of new error causes
    function [1:0] ddeh_pri;
        input desc_err;
        input zlen_err;
        input data_err;
        begin
            if (desc_err) begin
                ddeh_pri = `DDEH_PRI_DESC;
            end else if (zlen_err) begin
                ddeh_pri = `DDEH_PRI_ZLEN;
            end else if (data_err) begin
                ddeh_pri = `DDEH_PRI_DATA;
            end else begin
                ddeh_pri = `DDEH_PRI_NONE;
            end
        end
    endfunction

    reg [31:0] ctrl_ff;
    reg [7:0] thr_ff;
    reg [7:0] dcnt_ff;
    reg dcnt_run_ff;
    reg dly_irq_ff;
    reg err_irq_ff;
    reg dm_int_ff, dm_slv_ff, dm_dec_ff;
    reg sg_int_ff, sg_slv_ff, sg_dec_ff;
    reg [PTR_W-1:0] cdp_ff;
    reg ptr_logged_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;

    wire [7:0] dly_field = ctrl_ff[`DDEH_CTRL_DLY_HI:`DDEH_CTRL_DLY_LO];
    wire dly_en = (SG_MODE != 0) && (dly_field != `DDEH_ZERO8); // RULE_01 RULE_06
    wire wr_ctrl = reg_wr && (reg_addr == `DDEH_REG_CTRL);
    wire wr_stat = reg_wr && (reg_addr == `DDEH_REG_STAT);
    wire wr_thr = reg_wr && (reg_addr == `DDEH_REG_THR);

    // Error causes, gated by build mode except the data response errors
    wire sg = (SG_MODE != 0);
    wire zlen_err = sg && desc_valid && (desc_length == 23'h000000); // RULE_12 RULE_14
    wire uflow_err = sg && (STS_LEN != 0) && rx_underflow; // RULE_13 RULE_14
    wire stale_err = sg && desc_valid && desc_complete; // RULE_17
    wire dslv_err = data_resp_valid && (data_resp == RESP_SLV); // RULE_15
    wire ddec_err = data_resp_valid && (data_resp == RESP_DEC); // RULE_16 RULE_22
    wire sslv_err = sg && sg_resp_valid && (sg_resp == RESP_SLV); // RULE_18
    wire sdec_err = sg && sg_resp_valid && (sg_resp == RESP_DEC); // RULE_19 RULE_22
    wire desc_err = stale_err || sslv_err || sdec_err;
    wire data_err = uflow_err || dslv_err || ddec_err;
    wire any_err = desc_err || zlen_err || data_err;
    wire [1:0] pri = ddeh_pri(desc_err, zlen_err, data_err); // RULE_21
    wire dly_hit = dly_en && dcnt_run_ff && !dly_irq_ff &&
                   (dcnt_ff + `DDEH_ONE8 >= dly_field); // RULE_25

    // Pointer chosen by the top-priority cause
    reg [PTR_W-1:0] err_ptr;
    always @* begin
        case (pri)
            `DDEH_PRI_DESC: err_ptr = sg_resp_valid ? sg_resp_addr : desc_addr;
            `DDEH_PRI_ZLEN: err_ptr = desc_addr;
            default: err_ptr = data_desc_addr;
        endcase
    end

    // Halt sequencing state machine
    always @* begin
        case (state_ff)
            ST_IDLE: nxt_state = (wr_ctrl && reg_wdata[`DDEH_CTRL_RS]) ? ST_RUN : ST_IDLE;
            ST_RUN: nxt_state = any_err ? ST_DRAIN : ST_RUN; // RULE_07
            ST_DRAIN: nxt_state = bus_outstanding ? ST_DRAIN : ST_HALT; // RULE_08
            ST_HALT: nxt_state = ST_HALT; // RULE_11
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge core_clk) begin
        if (srst) begin
            state_ff <= ST_IDLE;
            ctrl_ff <= `DDEH_CTRL_RST;
            thr_ff <= `DDEH_THR_RST;
            run_ff <= 1'b0;
            halted_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            if (wr_thr) begin
                thr_ff <= reg_wdata[7:0];
            end
            // Error forces run bit low; errored channel ignores run writes
            if (any_err || state_ff == ST_DRAIN || state_ff == ST_HALT) begin
                ctrl_ff <= {ctrl_ff[31:1], 1'b0}; // RULE_07 RULE_11
            end else if (wr_ctrl) begin
                ctrl_ff <= reg_wdata;
            end
            run_ff <= (nxt_state == ST_RUN);
            halted_ff <= (nxt_state == ST_HALT) || (nxt_state == ST_IDLE); // RULE_08
        end
    end

    // Delay timer
    always @(posedge core_clk) begin
        if (srst) begin
            dcnt_ff <= `DDEH_ZERO8;
            dcnt_run_ff <= 1'b0;
            dly_irq_ff <= 1'b0;
            thr_reload_ff <= 1'b0;
        end else begin
            thr_reload_ff <= dly_hit || wr_thr; // RULE_23
            if (!dly_en) begin
                dcnt_ff <= `DDEH_ZERO8; // RULE_01
                dcnt_run_ff <= 1'b0;
            end else if (dly_hit) begin
                dcnt_ff <= `DDEH_ZERO8; // RULE_04
                dcnt_run_ff <= 1'b0;
            end else if (desc_valid && desc_sof) begin
                dcnt_ff <= `DDEH_ZERO8; // RULE_03
                dcnt_run_ff <= desc_eof;
            end else if (desc_valid && desc_eof) begin
                dcnt_ff <= `DDEH_ZERO8; // RULE_02
                dcnt_run_ff <= 1'b1;
            end else if (dcnt_run_ff && !dly_irq_ff) begin
                dcnt_ff <= dcnt_ff + `DDEH_ONE8; // RULE_04 RULE_05
            end
            // Set wins over software clear
            if (dly_hit) begin
                dly_irq_ff <= 1'b1; // RULE_25
            end else if (wr_stat && reg_wdata[`DDEH_ST_DLY_IRQ]) begin
                dly_irq_ff <= 1'b0; // RULE_05
            end
        end
    end

    // Sticky error bits and pointer log
    always @(posedge core_clk) begin
        if (srst) begin
            {dm_int_ff, dm_slv_ff, dm_dec_ff} <= 3'h0;
            {sg_int_ff, sg_slv_ff, sg_dec_ff} <= 3'h0;
            err_irq_ff <= 1'b0;
            cdp_ff <= {PTR_W{1'b0}};
            ptr_logged_ff <= 1'b0;
        end else begin
            // Status only, nothing written back to memory
            if (zlen_err || uflow_err) dm_int_ff <= 1'b1; // RULE_20
            if (dslv_err) dm_slv_ff <= 1'b1;
            if (ddec_err) dm_dec_ff <= 1'b1;
            if (stale_err) sg_int_ff <= 1'b1;
            if (sslv_err) sg_slv_ff <= 1'b1;
            if (sdec_err) sg_dec_ff <= 1'b1;
            if (any_err) begin
                err_irq_ff <= 1'b1;
            end else if (wr_stat && reg_wdata[`DDEH_ST_ERR_IRQ]) begin
                err_irq_ff <= 1'b0;
            end
            // First error only; later ones leave the pointer alone
            if (sg && any_err && !ptr_logged_ff) begin
                cdp_ff <= err_ptr; // RULE_09 RULE_10
                ptr_logged_ff <= 1'b1;
            end
        end
    end

    // Interrupt output and register read port
    always @(posedge core_clk) begin
        if (srst) begin
            introut_ff <= 1'b0;
            reg_rdata_ff <= `DDEH_ZERO32;
        end else begin
            introut_ff <= sg && ((dly_irq_ff && ctrl_ff[`DDEH_CTRL_DLY_IEN]) ||
                          (err_irq_ff && ctrl_ff[`DDEH_CTRL_ERR_IEN])); // RULE_24
            reg_rdata_ff <= `DDEH_ZERO32;
            if (reg_rd) begin
                case (reg_addr)
                    `DDEH_REG_CTRL: reg_rdata_ff <= ctrl_ff;
                    `DDEH_REG_STAT: begin
                        reg_rdata_ff[`DDEH_ST_HALTED] <= halted_ff;
                        reg_rdata_ff[`DDEH_ST_DM_INT] <= dm_int_ff;
                        reg_rdata_ff[`DDEH_ST_DM_SLV] <= dm_slv_ff;
                        reg_rdata_ff[`DDEH_ST_DM_DEC] <= dm_dec_ff;
                        reg_rdata_ff[`DDEH_ST_SG_INT] <= sg_int_ff;
                        reg_rdata_ff[`DDEH_ST_SG_SLV] <= sg_slv_ff;
                        reg_rdata_ff[`DDEH_ST_SG_DEC] <= sg_dec_ff;
                        reg_rdata_ff[`DDEH_ST_DLY_IRQ] <= dly_irq_ff;
                        reg_rdata_ff[`DDEH_ST_ERR_IRQ] <= err_irq_ff;
                        reg_rdata_ff[`DDEH_ST_DCNT_HI:`DDEH_ST_DCNT_LO] <= dcnt_ff;
                    end
                    `DDEH_REG_CDP: reg_rdata_ff <= cdp_ff[31:0];
                    `DDEH_REG_THR: reg_rdata_ff <= {24'h000000, thr_ff};
                    default: reg_rdata_ff <= `DDEH_ZERO32;
                endcase
            end
        end
    end

endmodule

// ==== tb/ddeh_chk_asserts.sv ====
module ddeh_chk #(
    parameter SG_MODE = 1,
    parameter STS_LEN = 1
) (
    input wire core_clk,
    input wire srst,
    input wire desc_valid,
    input wire desc_complete,
    input wire [22:0] desc_length,
    input wire rx_underflow,
    input wire data_resp_valid,
    input wire [1:0] data_resp,
    input wire sg_resp_valid,
    input wire [1:0] sg_resp,
    input wire bus_outstanding,
    input wire run_ff,
    input wire halted_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Error causes while running
    wire e_dat = run_ff && data_resp_valid && data_resp[1];
    wire e_sg = run_ff && sg_resp_valid && sg_resp[1];
    wire e_zl = run_ff && desc_valid && desc_length == 23'h0 && SG_MODE != 0;
    wire e_st = run_ff && desc_valid && desc_complete;
    wire e_un = run_ff && rx_underflow && STS_LEN != 0;
    logic err_ff;
    // Remembers that an error stopped the channel
    always @(posedge core_clk) begin
        if (srst)
            err_ff <= 1'b0;
        else if (e_dat || e_sg || e_zl || e_st || e_un)
            err_ff <= 1'b1;
    end
    sequence s_drained; err_ff && !bus_outstanding; endsequence
    property p_dat; e_dat |=> !run_ff; endproperty
    property p_sg; e_sg |=> !run_ff; endproperty
    property p_zl; e_zl |=> !run_ff; endproperty
    property p_st; e_st |=> !run_ff; endproperty
    property p_un; e_un |=> !run_ff; endproperty
    property p_norun; err_ff |-> !$rose(run_ff); endproperty
    property p_hwait; $rose(halted_ff) |-> !$past(bus_outstanding); endproperty
    property p_hdue; s_drained |-> ##[1:2] halted_ff; endproperty
    a_dat: assert property (p_dat)
        else $error("run kept after data error");
    a_sg: assert property (p_sg)
        else $error("run kept after descriptor bus error");
    a_zl: assert property (p_zl)
        else $error("run kept after zero length");
    a_st: assert property (p_st)
        else $error("run kept after stale descriptor");
    a_un: assert property (p_un)
        else $error("run kept after underflow");
    a_norun: assert property (p_norun)
        else $error("run restarted without reset");
    a_hwait: assert property (p_hwait)
        else $error("halted while transfers pending");
    a_hdue: assert property (p_hdue)
        else $error("halted missing after drain");
endmodule

bind ddeh_channel ddeh_chk #(.SG_MODE(SG_MODE), .STS_LEN(STS_LEN)) u_chk (
    .core_clk(core_clk), .srst(srst), .desc_valid(desc_valid),
    .desc_complete(desc_complete), .desc_length(desc_length), .rx_underflow(rx_underflow),
    .data_resp_valid(data_resp_valid), .data_resp(data_resp), .sg_resp_valid(sg_resp_valid),
    .sg_resp(sg_resp), .bus_outstanding(bus_outstanding), .run_ff(run_ff),
    .halted_ff(halted_ff));

// ==== tb/ddeh_slave.sv ====
module ddeh_slave (
    input wire core_clk,
    input wire srst,
    input wire req,
    input wire req_sg,
    input wire [1:0] req_code,
    input wire [3:0] req_lat,
    output logic bus_outstanding,
    output logic data_resp_valid,
    output logic [1:0] data_resp,
    output logic sg_resp_valid,
    output logic [1:0] sg_resp
);
    logic [3:0] cnt_ff;
    logic [3:0] tail_ff;
    logic sg_ff;
    logic [1:0] code_ff;
    // Answers after a latency, then keeps other beats pending
    always @(posedge core_clk) begin
        data_resp_valid <= 1'b0;
        sg_resp_valid <= 1'b0;
        data_resp <= ~data_resp;
        sg_resp <= ~sg_resp;
        if (srst) begin
            cnt_ff <= 4'h0;
            tail_ff <= 4'h0;
            data_resp <= 2'h1;
            sg_resp <= 2'h1;
        end else if (req) begin
            cnt_ff <= req_lat;
            sg_ff <= req_sg;
            code_ff <= req_code;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
            tail_ff <= 4'h3;
            if (cnt_ff == 4'h1 && sg_ff) begin
                sg_resp_valid <= 1'b1;
                sg_resp <= code_ff;
            end else if (cnt_ff == 4'h1) begin
                data_resp_valid <= 1'b1;
                data_resp <= code_ff;
            end
        end else if (tail_ff != 4'h0)
            tail_ff <= tail_ff - 4'h1;
    end
    assign bus_outstanding = cnt_ff != 4'h0 || tail_ff != 4'h0;
endmodule

// ==== tb/tb_dma_delay_irq_error_halt.sv ====
module tb_dma_delay_irq_error_halt;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic desc_valid = 1'b0, desc_sof = 1'b0, desc_eof = 1'b0, desc_complete = 1'b0;
    logic rx_underflow = 1'b0, req = 1'b0, req_sg = 1'b0;
    logic [3:0] reg_addr = 4'h0, req_lat = 4'h1;
    logic [1:0] req_code = 2'h0, data_resp, sg_resp;
    logic [22:0] desc_length = 23'h40;
    logic [31:0] reg_wdata = 32'h0, desc_addr = 32'h0, data_desc_addr = 32'h0;
    logic [31:0] sg_resp_addr = 32'h0, reg_rdata_ff, st, lat, seed = 32'hB4AECFFC;
    logic data_resp_valid, sg_resp_valid, bus_outstanding, run_ff, halted_ff, introut_ff;
    logic thr_reload_ff;
    int err_total = 0, compares = 0, reloads = 0, k;
    ddeh_channel dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .desc_valid(desc_valid), .desc_sof(desc_sof), .desc_eof(desc_eof),
        .desc_complete(desc_complete), .desc_length(desc_length), .desc_addr(desc_addr),
        .data_desc_addr(data_desc_addr), .rx_underflow(rx_underflow),
        .data_resp_valid(data_resp_valid), .data_resp(data_resp),
        .sg_resp_valid(sg_resp_valid), .sg_resp(sg_resp), .sg_resp_addr(sg_resp_addr),
        .bus_outstanding(bus_outstanding), .run_ff(run_ff), .halted_ff(halted_ff),
        .introut_ff(introut_ff), .thr_reload_ff(thr_reload_ff));
    ddeh_slave u_slave (.core_clk(core_clk), .srst(srst), .req(req), .req_sg(req_sg),
        .req_code(req_code), .req_lat(req_lat), .bus_outstanding(bus_outstanding),
        .data_resp_valid(data_resp_valid), .data_resp(data_resp),
        .sg_resp_valid(sg_resp_valid), .sg_resp(sg_resp));
    // Clock and reload pulse count
    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (thr_reload_ff === 1'b1) reloads++;
    task automatic finish_test;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // Read data stand only in the cycle after the strobe
        #1 st = reg_rdata_ff;
        @(posedge core_clk);
    endtask
    task automatic wait_for(input int w);
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            #1;
            if ((w == 0 && run_ff === 1'b0) || (w == 1 && halted_ff === 1'b1)
                || (w == 2 && introut_ff === 1'b1)) return;
        end
        chk("wait", 32'h1, 32'h0);
        finish_test();
    endtask
    // Expected status and logged pointer per error kind
    function automatic logic [31:0] exp_st(input int n);
        case (n)
            0: return 32'h00004021;
            1: return 32'h00004041;
            2: return 32'h00004011;
            3: return 32'h00004101;
            4: return 32'h00004201;
            5: return 32'h00004401;
            6: return 32'h00004011;
            default: return 32'h00004111;
        endcase
    endfunction
    function automatic logic [31:0] exp_ptr(input int n);
        if (n == 4 || n == 5) return sg_resp_addr;
        if (n == 2 || n == 3 || n == 7) return desc_addr;
        return data_desc_addr;
    endfunction
    task automatic do_reset;
        srst <= 1'b1;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
    endtask
    // Delay timer, then every error kind after its own reset
    initial begin
        do_reset();
        rd(4'h0);
        chk("ctrl_rst", 32'h0, st);
        rd(4'hF);
        chk("unmapped", 32'h0, st);
        wr(4'h0, 32'h03002001);
        desc_valid <= 1'b1;
        desc_eof <= 1'b1;
        @(posedge core_clk);
        desc_valid <= 1'b0;
        desc_eof <= 1'b0;
        wait_for(2);
        rd(4'h1);
        chk("dly_flag", 32'h00002000, st & 32'hFF002000);
        repeat (8) @(posedge core_clk);
        rd(4'h1);
        chk("dly_hold", 32'h00002000, st & 32'hFF002000);
        wr(4'h1, 32'h00002000);
        rd(4'h1);
        chk("dly_clr", 32'h0, st & 32'h00002000);
        chk("reloads", 32'h1, reloads);
        for (k = 0; k < 8; k++) begin
            do_reset();
            desc_addr <= $random(seed);
            data_desc_addr <= $random(seed);
            sg_resp_addr <= $random(seed);
            wr(4'h0, 32'h00004001);
            #1 chk("run_on", 32'h1, {31'h0, run_ff});
            lat = $random(seed);
            req <= 1'b1;
            req_sg <= k == 4 || k == 5;
            req_code <= (k < 2 || k == 4 || k == 5) ? {1'b1, k[0]} : 2'h0;
            req_lat <= {1'b0, lat[2:0]} + 4'h1;
            desc_valid <= k == 2 || k == 3 || k == 7;
            desc_complete <= k == 3 || k == 7;
            desc_length <= k == 2 ? 23'h0 : lat[22:0] | 23'h1;
            rx_underflow <= k == 6 || k == 7;
            @(posedge core_clk);
            req <= 1'b0;
            desc_valid <= 1'b0;
            rx_underflow <= 1'b0;
            wait_for(0);
            if (bus_outstanding === 1'b1) chk("early", 32'h0, {31'h0, halted_ff});
            wait_for(1);
            rd(4'h1);
            chk("status", exp_st(k), st & 32'h00004771);
            chk("introut", 32'h1, {31'h0, introut_ff});
            rd(4'h2);
            chk("cdp", exp_ptr(k), st);
            wr(4'h0, 32'h00000001);
            @(posedge core_clk);
            #1 chk("restart", 32'h0, {31'h0, run_ff});
        end
        finish_test();
    end
endmodule
